// *** hw/aif_pkg.sv ***
package aif_pkg;
  // ==========================================
  // register offsets (byte addresses)
  // printed offsets are word indices, the bus sees four times that
  localparam logic [7:0] IDX_SEC_IRQ = 8'h05;
  localparam logic [7:0] IDX_ERR = 8'h06;
  localparam logic [7:0] ADDR_SEC_IRQ = IDX_SEC_IRQ << 2;
  localparam logic [7:0] ADDR_ERR = IDX_ERR << 2;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PRI_STAT = 8'h1c;
  // ==========================================
  // secondary request fields
  localparam int SEC_SET_SEL = 7;
  localparam int SEC_EDGE = 4;
  localparam int SEC_CRC = 2;
  localparam logic [7:0] SEC_MASK = 8'h14;
  // ==========================================
  // error fields
  localparam int ERR_WR = 7;
  localparam int ERR_TEMP = 6;
  localparam int ERR_OVFL = 4;
  localparam int ERR_COLL = 3;
  localparam int ERR_CRC = 2;
  localparam int ERR_PAR = 1;
  localparam int ERR_SOF = 0;
  localparam int ERR_RSVD = 5;
  localparam logic [7:0] ERR_RESET = 8'h00;
  localparam logic [7:0] ERR_RX_CLR = 8'h0f;
  localparam logic [7:0] ERR_CMD_CLR = 8'hbf;
  // ==========================================
  // control and status fields
  localparam int CTL_CRC_EN = 2;
  localparam int CTL_EDGE_EN = 4;
  localparam logic [7:0] CTL_MASK = 8'h14;
  localparam int PRI_ERR_SUM = 1;
  localparam int PRI_IRQ = 0;
  // ==========================================
  // link rates and bus response codes
  localparam logic [1:0] RATE_106 = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hw/aif_flags.sv ***
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - bit 7 chooses set or clear on write
// - request flags stay until software clears
// - request register 05h, reserved bits zero
// - any edge on aux input sets bit 4 (here only a level held two clocks, once the synchroniser is primed)
// - crc compute finished sets bit 2
// - error register 06h, resets to zero
// - fifo write during authenticate sets bit 7
// - fifo write in rf turnaround sets bit 7
// - overheat sets bit 6, antenna off
// - write to full fifo sets bit 4
// - collision sets bit 3 at 106 kBd
// - collision held zero at higher rates
// - receiver start clears low four errors
// - failed crc with check enabled sets bit 2
// - parity fail sets bit 1
// - bad start of frame sets bit 0
// - wrong byte count in authenticate sets bit 0
// - command start clears all but overheat
// - software cannot set overheat
// - any error raises error summary request
// - crc request to pin when enabled
// - edge request to pin when enabled
module aif_flags
  import aif_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // device events, same clock except the aux input, which is synchronised
  input wire logic aux_serial_input,
  input wire logic crc_compute_command,
  input wire logic crc_data_done,
  input wire logic card_authenticate_command,
  input wire logic host_fifo_write,
  input wire logic rf_turnaround,
  input wire logic fifo_full,
  input wire logic internal_fifo_write,
  input wire logic overheat_detect,
  input wire logic collision_detect,
  input wire logic [1:0] link_rate,
  input wire logic rx_startup,
  input wire logic rx_crc_check_enable,
  input wire logic crc_fail,
  input wire logic parity_fail,
  input wire logic sof_bad,
  input wire logic auth_byte_count_bad,
  input wire logic command_start,
  // outputs
  output logic antenna_off,
  output logic error_summary_irq,
  output logic irq_out
);
  // ==========================================
  // aux input synchroniser
  logic [2:0] aux_sync;
  logic aux_state;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_sync <= 3'h0;
    end else begin
      aux_sync <= {aux_sync[1:0], aux_serial_input};
    end
  end
  // chain holds reset zeros for three edges; priming waits until it is full,
  // else a pin that idles high fakes an edge right after reset
  logic [1:0] aux_fill;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_fill <= 2'h0;
    end else if (aux_fill != 2'h3) begin
      aux_fill <= aux_fill + 2'h1;
    end
  end
  logic aux_primed;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_state <= 1'b0;
      aux_primed <= 1'b0;
    end else if (aux_fill == 2'h3 && aux_sync[2] == aux_sync[1]) begin
      aux_state <= aux_sync[2];
      aux_primed <= 1'b1;
    end
  end
  wire aux_edge = aux_primed && (aux_sync[2] == aux_sync[1]) && (aux_sync[2] != aux_state);

  // ==========================================
  // axi write channel
  function automatic logic addr_ok(input logic [7:0] a);
    return a == ADDR_SEC_IRQ || a == ADDR_ERR || a == ADDR_IRQ_CTRL || a == ADDR_PRI_STAT;
  endfunction
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_lane0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (aw_held && w_held) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_ok(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        // both halves reopen only once the answer has gone
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  wire wr_go = aw_held && w_held && w_lane0;

  // ==========================================
  // secondary request register
  logic [7:0] sec_irq;
  logic [7:0] sec_hw;
  always_comb begin
    sec_hw = 8'h00;
    sec_hw[SEC_EDGE] = aux_edge;
    sec_hw[SEC_CRC] = crc_compute_command && crc_data_done;
  end
  logic [7:0] next_sec;
  always_comb begin
    next_sec = sec_irq;
    if (wr_go && aw_addr == ADDR_SEC_IRQ) begin
      if (w_byte[SEC_SET_SEL]) begin
        next_sec = sec_irq | (w_byte & SEC_MASK);
      end else begin
        next_sec = sec_irq & ~(w_byte & SEC_MASK);
      end
    end
    // hardware set beats a software clear in the same cycle
    next_sec = (next_sec | sec_hw) & SEC_MASK;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec_irq <= 8'h00;
    end else begin
      sec_irq <= next_sec;
    end
  end

  // ==========================================
  // control register: pin enables
  logic [7:0] irq_ctrl;
  logic [7:0] next_ctrl;
  always_comb begin
    next_ctrl = irq_ctrl;
    if (wr_go && aw_addr == ADDR_IRQ_CTRL) begin
      next_ctrl = w_byte & CTL_MASK;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ctrl <= 8'h00;
    end else begin
      irq_ctrl <= next_ctrl;
    end
  end

  // ==========================================
  // error register, read only from the bus
  logic [7:0] err;
  logic [7:0] err_set;
  always_comb begin
    err_set = 8'h00;
    err_set[ERR_WR] = host_fifo_write && (card_authenticate_command || rf_turnaround);
    err_set[ERR_TEMP] = overheat_detect;
    err_set[ERR_OVFL] = fifo_full && (host_fifo_write || internal_fifo_write);
    err_set[ERR_COLL] = collision_detect && link_rate == RATE_106;
    err_set[ERR_CRC] = rx_crc_check_enable && crc_fail;
    err_set[ERR_PAR] = parity_fail;
    err_set[ERR_SOF] = sof_bad || (card_authenticate_command && auth_byte_count_bad);
  end
  logic [7:0] next_err;
  always_comb begin
    next_err = err;
    if (command_start) begin
      next_err = next_err & ~ERR_CMD_CLR;
    end
    if (rx_startup) begin
      next_err = next_err & ~ERR_RX_CLR;
    end
    if (link_rate != RATE_106) begin
      next_err[ERR_COLL] = 1'b0;
    end
    next_err = next_err | err_set;
    next_err[ERR_RSVD] = 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err <= ERR_RESET;
    end else begin
      err <= next_err;
    end
  end

  // ==========================================
  // outputs, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      antenna_off <= 1'b0;
      error_summary_irq <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      antenna_off <= next_err[ERR_TEMP];
      error_summary_irq <= |next_err;
      // pin follows an enable in the very cycle that it is written
      irq_out <= (next_sec[SEC_CRC] && next_ctrl[CTL_CRC_EN])
        || (next_sec[SEC_EDGE] && next_ctrl[CTL_EDGE_EN]);
    end
  end

  // ==========================================
  // axi read channel
  logic [7:0] rd_byte;
  always_comb begin
    unique case (s_axi_araddr)
      ADDR_SEC_IRQ: rd_byte = sec_irq;
      ADDR_ERR: rd_byte = err;
      ADDR_IRQ_CTRL: rd_byte = irq_ctrl;
      ADDR_PRI_STAT: rd_byte = {6'h00, error_summary_irq, irq_out};
      default: rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_arready <= 1'b0;
      s_axi_rdata <= {24'h0, rd_byte};
      s_axi_rresp <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================
  // checks
  chk_set_clear_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && aw_addr == ADDR_SEC_IRQ && w_byte[SEC_SET_SEL] && w_byte[SEC_CRC]
    |=> sec_irq[SEC_CRC]) else $error("set write lost crc flag");
  chk_sec_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    sec_irq[SEC_EDGE] && !(wr_go && aw_addr == ADDR_SEC_IRQ) |=> sec_irq[SEC_EDGE])
    else $error("edge flag dropped by itself");
  chk_sec_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    (sec_irq & ~SEC_MASK) == 8'h00) else $error("reserved request bit set");
  chk_edge_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    aux_edge |=> sec_irq[SEC_EDGE]) else $error("edge not recorded");
  chk_crc_done: assert property (@(posedge aclk) disable iff (!aresetn)
    crc_compute_command && crc_data_done |=> sec_irq[SEC_CRC])
    else $error("crc done not recorded");
  chk_err_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    !err[ERR_RSVD]) else $error("reserved error bit set");
  chk_wr_violation: assert property (@(posedge aclk) disable iff (!aresetn)
    host_fifo_write && (card_authenticate_command || rf_turnaround) |=> err[ERR_WR])
    else $error("fifo write violation not recorded");
  chk_overheat_set: assert property (@(posedge aclk) disable iff (!aresetn)
    overheat_detect |=> err[ERR_TEMP] && antenna_off)
    else $error("overheat not recorded");
  chk_antenna_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 antenna_off == err[ERR_TEMP]) else $error("antenna state out of step");
  chk_overflow_set: assert property (@(posedge aclk) disable iff (!aresetn)
    fifo_full && (host_fifo_write || internal_fifo_write) |=> err[ERR_OVFL])
    else $error("overflow not recorded");
  chk_coll_set: assert property (@(posedge aclk) disable iff (!aresetn)
    collision_detect && link_rate == RATE_106 |=> err[ERR_COLL])
    else $error("collision not recorded");
  chk_coll_rate: assert property (@(posedge aclk) disable iff (!aresetn)
    link_rate != RATE_106 |=> !err[ERR_COLL]) else $error("collision at high rate");
  chk_rx_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_startup && err_set == 8'h00 |=> (err & ERR_RX_CLR) == 8'h00)
    else $error("receiver start clear wrong");
  chk_crc_err: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_crc_check_enable && crc_fail |=> err[ERR_CRC]) else $error("crc error not recorded");
  chk_parity_set: assert property (@(posedge aclk) disable iff (!aresetn)
    parity_fail |=> err[ERR_PAR]) else $error("parity error not recorded");
  chk_frame_start: assert property (@(posedge aclk) disable iff (!aresetn)
    sof_bad || (card_authenticate_command && auth_byte_count_bad) |=> err[ERR_SOF])
    else $error("frame start error not recorded");
  chk_cmd_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    command_start && err_set == 8'h00 |=> (err & ERR_CMD_CLR) == 8'h00
    && err[ERR_TEMP] == $past(err[ERR_TEMP])) else $error("command start clear wrong");
  chk_heat_source: assert property (@(posedge aclk) disable iff (!aresetn)
    !err[ERR_TEMP] && !overheat_detect |=> !err[ERR_TEMP])
    else $error("overheat set without sensor");
  chk_err_summary: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 error_summary_irq == (|err)) else $error("summary out of step");
  chk_irq_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 irq_out == ((sec_irq[SEC_CRC] && irq_ctrl[CTL_CRC_EN])
    || (sec_irq[SEC_EDGE] && irq_ctrl[CTL_EDGE_EN]))) else $error("irq pin wrong");
  chk_ctrl_reserved: assert property (@(posedge aclk) disable iff (!aresetn)
    (irq_ctrl & ~CTL_MASK) == 8'h00) else $error("reserved enable bit set");
endmodule // aif_flags
`default_nettype wire

// *** testbench/aif_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host side of the register bus
module aif_host_model (
  // clock
  input wire logic aclk,
  // write
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // released payload shows the inverse, so a stale value never passes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                    output bit to);
    to = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 100 && to; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        to = 1'b0;
      end
    end
    awaddr <= ~a;
    wdata <= ~d;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r,
                    output bit to);
    to = 1'b1;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 100 && to; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        to = 1'b0;
      end
    end
    araddr <= ~a;
    arvalid <= 1'b0;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule // aif_host_model
`default_nettype wire

// *** testbench/aif_flags_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module aif_flags_tb_top
  import aif_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic aux = 1'b0;
  logic [1:0] rate = 2'h0;
  logic [15:0] ev = 16'h0000;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic antenna_off, error_summary_irq, irq_out;
  int err_total = 0;
  int checks_done = 0;
  always #5 aclk = ~aclk;
  aif_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  aif_flags dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .aux_serial_input(aux), .crc_compute_command(ev[0]), .crc_data_done(ev[1]),
    .card_authenticate_command(ev[2]), .host_fifo_write(ev[3]), .rf_turnaround(ev[4]),
    .fifo_full(ev[5]), .internal_fifo_write(ev[6]), .overheat_detect(ev[7]),
    .collision_detect(ev[8]), .link_rate(rate), .rx_startup(ev[9]),
    .rx_crc_check_enable(ev[10]), .crc_fail(ev[11]), .parity_fail(ev[12]), .sof_bad(ev[13]),
    .auth_byte_count_bad(ev[14]), .command_start(ev[15]), .antenna_off(antenna_off),
    .error_summary_irq(error_summary_irq), .irq_out(irq_out));
  // ==========================================
  // checking and closing
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // a hung handshake ends the run at once
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    bit to;
    host.wr(a, {24'h0, d}, r, to);
    if (to) err_total++;
    if (to) conclude();
    chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    bit to;
    host.rd(a, d, r, to);
    if (to) err_total++;
    if (to) conclude();
    chk(what, d, exp);
    chk("rresp", {30'h0, r}, {30'h0, er});
  endtask
  task automatic pulse(input logic [15:0] m);
    ev <= m;
    @(posedge aclk);
    ev <= 16'h0000;
    repeat (2) @(posedge aclk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    rchk("sec reset", ADDR_SEC_IRQ, 32'h0, RESP_OKAY);
    rchk("err reset", ADDR_ERR, {24'h0, ERR_RESET}, RESP_OKAY);
    rchk("unmapped", 8'h40, 32'h0, RESP_SLVERR);
    chk("outs idle", {29'h0, antenna_off, error_summary_irq, irq_out}, 32'h0);
  endtask
  task automatic t_soft();
    w(ADDR_SEC_IRQ, 8'hff);
    rchk("set all", ADDR_SEC_IRQ, 32'h14, RESP_OKAY);
    w(ADDR_SEC_IRQ, 8'h04);
    rchk("clear one", ADDR_SEC_IRQ, 32'h10, RESP_OKAY);
    w(ADDR_SEC_IRQ, 8'h00);
    rchk("zero keeps", ADDR_SEC_IRQ, 32'h10, RESP_OKAY);
    w(ADDR_SEC_IRQ, 8'h7f);
    rchk("clear all", ADDR_SEC_IRQ, 32'h0, RESP_OKAY);
  endtask
  task automatic t_events();
    aux <= 1'b1;
    repeat (8) @(posedge aclk);
    rchk("rise", ADDR_SEC_IRQ, 32'h10, RESP_OKAY);
    w(ADDR_SEC_IRQ, 8'h10);
    aux <= 1'b0;
    repeat (8) @(posedge aclk);
    pulse(16'h0001);
    rchk("fall", ADDR_SEC_IRQ, 32'h10, RESP_OKAY);
    pulse(16'h0003);
    repeat (20) @(posedge aclk);
    rchk("crc kept", ADDR_SEC_IRQ, 32'h14, RESP_OKAY);
    chk("masked", {31'h0, irq_out}, 32'h0);
    w(ADDR_IRQ_CTRL, 8'h04);
    chk("crc pin", {31'h0, irq_out}, 32'h1);
    w(ADDR_SEC_IRQ, 8'h04);
    chk("crc gone", {31'h0, irq_out}, 32'h0);
    w(ADDR_IRQ_CTRL, 8'h10);
    chk("edge pin", {31'h0, irq_out}, 32'h1);
    rchk("status", ADDR_PRI_STAT, 32'h1, RESP_OKAY);
    rchk("enables", ADDR_IRQ_CTRL, 32'h10, RESP_OKAY);
    w(ADDR_IRQ_CTRL, 8'hff);
    rchk("enable reserved", ADDR_IRQ_CTRL, 32'h14, RESP_OKAY);
  endtask
  task automatic t_errors();
    logic [15:0] cause [9] = '{16'h000c, 16'h0018, 16'h0060, 16'h0100, 16'h0c00, 16'h1000,
      16'h2000, 16'h4004, 16'h0800};
    logic [7:0] flag [9] = '{8'h80, 8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h01, 8'h00};
    for (int i = 0; i < 9; i++) begin
      pulse(cause[i]);
      rchk("err set", ADDR_ERR, {24'h0, flag[i]}, RESP_OKAY);
      chk("summary", {31'h0, error_summary_irq}, {31'h0, |flag[i]});
      pulse(16'h8000);
      rchk("cmd clear", ADDR_ERR, 32'h0, RESP_OKAY);
    end
    rate <= 2'h1;
    pulse(16'h0100);
    rchk("coll fast", ADDR_ERR, 32'h0, RESP_OKAY);
    rate <= RATE_106;
    pulse(16'h3d0c);
    rchk("many", ADDR_ERR, 32'h8f, RESP_OKAY);
    pulse(16'h0200);
    rchk("rx start", ADDR_ERR, 32'h80, RESP_OKAY);
    pulse(16'h0080);
    rchk("heat", ADDR_ERR, 32'hc0, RESP_OKAY);
    chk("antenna", {31'h0, antenna_off}, 32'h1);
    pulse(16'h8000);
    rchk("heat stays", ADDR_ERR, 32'h40, RESP_OKAY);
    w(ADDR_ERR, 8'hff);
    rchk("no soft set", ADDR_ERR, 32'h40, RESP_OKAY);
    rchk("status err", ADDR_PRI_STAT, 32'h3, RESP_OKAY);
  endtask
  // overheat only leaves through reset, so a second reset must clear it
  task automatic t_midreset();
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_soft();
    t_events();
    t_errors();
    t_midreset();
    conclude();
  end
endmodule // aif_flags_tb_top
`default_nettype wire
